// *** verilog/pps_pkg.sv ***
// Shared constants, register map and state codes of the PHY power-state manager.
// Assumes a single 200 MHz core clock; all times but CFG_DEADLINE_MS are turned into cycle counts here.
package pps_pkg;
  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 200;
  localparam int BREAK_MIN_MS = 1200;
  localparam int BREAK_MAX_MS = 1300;
  localparam int LED_HOLD_MS = 2000;
  localparam int CFG_DEADLINE_MS = 500;
  // Least times round up; these products are exact at 200 MHz
  localparam int BREAK_CYC = BREAK_MIN_MS * CLK_MHZ * 1000;
  localparam int BREAK_MAX_CYC = BREAK_MAX_MS * CLK_MHZ * 1000;
  localparam int LED_CYC = LED_HOLD_MS * CLK_MHZ * 1000;
  localparam int TMR_W = 32;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam int CTRL_PD_MODE_BIT = 0;
  localparam int CTRL_LPI_EN_BIT = 1;
  localparam int CTRL_PWR_DOWN_BIT = 11;
  localparam logic CTRL_PD_MODE_RST = 1'h1;
  localparam logic CTRL_LPI_EN_RST = 1'h0;
  localparam logic CTRL_PWR_DOWN_RST = 1'h0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CABLE_BIT = 4;
  localparam int STAT_RX_LPI_BIT = 5;
  localparam int STAT_TX_LPI_BIT = 6;
  localparam int STAT_PHY_PD_BIT = 7;
  localparam int STAT_LED_BIT = 8;

  // ************************************************************
  // Power states, Gray coded along the usual path
  // ************************************************************
  typedef enum logic [3:0] {
    ST_PWR_UP = 4'h0,
    ST_IF_INIT = 4'h1,
    ST_CFG_WAIT = 4'h3,
    ST_NO_LINK = 4'h2,
    ST_ACTIVE = 4'h6,
    ST_IDLE = 4'h7,
    ST_CABLE_DISC = 4'h5,
    ST_BREAK_WAIT = 4'h4,
    ST_IEEE_PD = 4'hC,
    ST_PIN_PD = 4'hD
  } pps_state_t;
endpackage

// *** verilog/pps_rst_sync.sv ***
// Reset release synchroniser for the power-state manager.
// Assumes rst_n_i may assert at any time; release is re-timed to core_clk_i.
`timescale 1ns/100ps
module pps_rst_sync (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_n_i,    // Asynchronous reset, active low
  output logic rst_n_o         // Synchronised reset, active low
);
  logic meta_reg;
  logic sync_reg;

  // ************************************************************
  // Two-stage release
  // ************************************************************
  // Assert at once, release after two edges to avoid a metastable release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      sync_reg <= meta_reg;
    end
  end

  assign rst_n_o = sync_reg;
endmodule

// *** verilog/pps_timer.sv ***
// Loadable down-counter used for the long waits of the power-state manager.
// Assumes load_i is a one-cycle pulse; done_o is high while the count is zero.
`timescale 1ns/100ps
module pps_timer #(
  parameter int W = 32,
  parameter int CYC = 16
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_n_i,    // Synchronised reset, active low
  input wire logic load_i,     // Start a fresh wait
  output logic done_o          // Wait has run out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Refuse counts that would not fit the counter or would be empty
  if (CYC < 1 || (W < 32 && CYC >= (1 << W))) begin : g_chk
    $error("pps_timer: count does not fit");
  end

  // ************************************************************
  // Count
  // ************************************************************
  // Reload wins over counting so a late restart is never lost
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = W'(CYC);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg == '0);
endmodule

// *** verilog/pps_power_mgr.sv ***
// Power-state manager of a gigabit Ethernet PHY with its register port.
// Assumes all inputs are synchronous to core_clk_i and in-band requests are levels.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module pps_power_mgr #(
  parameter int BREAK_CYC = pps_pkg::BREAK_CYC,
  parameter int LED_CYC = pps_pkg::LED_CYC
) (
  input wire logic core_clk_i,          // Core clock, 200 MHz
  input wire logic rst_n_i,             // Power-on reset, active low
  input wire logic [7:0] reg_addr_i,    // Register byte address
  input wire logic [31:0] reg_wdata_i,  // Register write data
  input wire logic reg_wr_i,            // Register write strobe
  input wire logic reg_rd_i,            // Register read strobe
  output logic [31:0] reg_rdata_o,      // Read data, cycle after strobe
  input wire logic lan_supply_good_n_i, // Supply good, low forces power down
  input wire logic lan_off_n_i,         // LAN-off pin, low forces power down
  input wire logic pcie_en_i,           // PCIe link is in use
  input wire logic link_init_done_i,    // Interconnect initialised
  input wire logic mdio_cfg_done_i,     // MAC finished MDIO configuration
  input wire logic mac_pd_req_i,        // In-band power-down request
  input wire logic mac_tx_lpi_req_i,    // In-band transmit LPI request
  input wire logic partner_lpi_i,       // Partner transmitter in LPI
  input wire logic energy_i,            // Energy seen on the line
  input wire logic link_up_i,           // Ethernet link established
  input wire logic traffic_i,           // Frames moving on the link
  output logic [3:0] state_o,           // Current power state
  output logic iface_rst_o,             // Interconnect held in reset
  output logic an_enable_o,             // Auto-negotiation may advertise
  output logic phy_pd_o,                // PHY analog powered down
  output logic clk_gate_o,              // Internal clocks gated
  output logic pcie_ei_o,               // PCIe in electrical idle
  output logic pcie_pd_o,               // PCIe link powered down
  output logic energy_mode_o,           // PHY in energy-detect mode
  output logic cable_gone_o,            // Cable-gone flag to the MAC
  output logic rx_lpi_ind_o,            // In-band receive LPI indication
  output logic rx_off_o,                // Receive circuitry off
  output logic tx_lpi_o,                // Transmit path in LPI
  output logic tx_off_o,                // Transmit circuitry off
  output logic link_led_o               // Link indicator
);
  logic rst_n;
  pps_pkg::pps_state_t state_reg, state_next;
  logic pd_mode_reg, pd_mode_next;
  logic lpi_en_reg, lpi_en_next;
  logic pwr_down_reg, pwr_down_next;
  logic [31:0] rdata_reg, rdata_next;
  logic phy_pd_reg, phy_pd_next;
  logic clk_gate_reg, clk_gate_next;
  logic pcie_ei_reg, pcie_ei_next;
  logic pcie_pd_reg, pcie_pd_next;
  logic energy_mode_reg, energy_mode_next;
  logic cable_gone_reg, cable_gone_next;
  logic rx_lpi_reg, rx_lpi_next;
  logic tx_lpi_reg, tx_lpi_next;
  logic iface_rst_reg, iface_rst_next;
  logic an_en_reg, an_en_next;
  logic led_reg, led_next;
  logic pin_pd;
  logic linked_now, linked_next;
  logic break_load, break_done;
  logic led_load, led_done;

  // ************************************************************
  // Reset and timers
  // ************************************************************
  pps_rst_sync u_rst (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .rst_n_o(rst_n)
  );

  pps_timer #(.W(pps_pkg::TMR_W), .CYC(BREAK_CYC)) u_break (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .load_i(break_load),
    .done_o(break_done)
  );

  pps_timer #(.W(pps_pkg::TMR_W), .CYC(LED_CYC)) u_led (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .load_i(led_load),
    .done_o(led_done)
  );

  // The break-link wait must not overrun its longest figure
  if (BREAK_CYC < 1 || BREAK_CYC >= pps_pkg::BREAK_MAX_CYC) begin : g_chk
    $error("pps_power_mgr: break-link wait out of range");
  end

  // ************************************************************
  // Register port
  // ************************************************************
  // Control writes and read data; unmapped reads return zero
  always_comb begin
    pd_mode_next = pd_mode_reg;
    lpi_en_next = lpi_en_reg;
    pwr_down_next = pwr_down_reg;
    rdata_next = '0;
    if (reg_wr_i && reg_addr_i == pps_pkg::CTRL_ADDR) begin
      pd_mode_next = reg_wdata_i[pps_pkg::CTRL_PD_MODE_BIT];
      lpi_en_next = reg_wdata_i[pps_pkg::CTRL_LPI_EN_BIT];
      pwr_down_next = reg_wdata_i[pps_pkg::CTRL_PWR_DOWN_BIT];
    end
    if (reg_rd_i && reg_addr_i == pps_pkg::CTRL_ADDR) begin
      rdata_next[pps_pkg::CTRL_PD_MODE_BIT] = pd_mode_reg;
      rdata_next[pps_pkg::CTRL_LPI_EN_BIT] = lpi_en_reg;
      rdata_next[pps_pkg::CTRL_PWR_DOWN_BIT] = pwr_down_reg;
    end else if (reg_rd_i && reg_addr_i == pps_pkg::STAT_ADDR) begin
      rdata_next[pps_pkg::STAT_STATE_LSB +: 4] = state_reg;
      rdata_next[pps_pkg::STAT_CABLE_BIT] = cable_gone_reg;
      rdata_next[pps_pkg::STAT_RX_LPI_BIT] = rx_lpi_reg;
      rdata_next[pps_pkg::STAT_TX_LPI_BIT] = tx_lpi_reg;
      rdata_next[pps_pkg::STAT_PHY_PD_BIT] = phy_pd_reg;
      rdata_next[pps_pkg::STAT_LED_BIT] = led_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_mode_reg <= pps_pkg::CTRL_PD_MODE_RST;
      lpi_en_reg <= pps_pkg::CTRL_LPI_EN_RST;
      pwr_down_reg <= pps_pkg::CTRL_PWR_DOWN_RST;
      rdata_reg <= '0;
    end else begin
      pd_mode_reg <= pd_mode_next;
      lpi_en_reg <= lpi_en_next;
      pwr_down_reg <= pwr_down_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Power-state machine
  // ************************************************************
  // Either pin forces power down, ahead of every in-band request
  assign pin_pd = !lan_supply_good_n_i || !lan_off_n_i;
  assign linked_now = (state_reg == pps_pkg::ST_ACTIVE) || (state_reg == pps_pkg::ST_IDLE);
  assign linked_next = (state_next == pps_pkg::ST_ACTIVE) || (state_next == pps_pkg::ST_IDLE);
  assign break_load = (state_reg == pps_pkg::ST_CABLE_DISC) && (state_next == pps_pkg::ST_BREAK_WAIT);
  assign led_load = linked_now && !linked_next;

  // Pins first, then software or in-band power down, then link events
  always_comb begin
    state_next = state_reg;
    if (pin_pd) begin
      state_next = pps_pkg::ST_PIN_PD;
    end else if (state_reg == pps_pkg::ST_PIN_PD) begin
      state_next = pps_pkg::ST_IF_INIT;
    end else if (pwr_down_reg || mac_pd_req_i) begin
      state_next = pps_pkg::ST_IEEE_PD;
    end else begin
      case (state_reg)
        pps_pkg::ST_PWR_UP: state_next = pps_pkg::ST_IF_INIT;
        pps_pkg::ST_IF_INIT: if (link_init_done_i) begin
          state_next = pps_pkg::ST_CFG_WAIT;
        end
        pps_pkg::ST_CFG_WAIT: if (mdio_cfg_done_i) begin
          state_next = pps_pkg::ST_NO_LINK;
        end
        pps_pkg::ST_NO_LINK: begin
          if (!energy_i) begin
            state_next = pps_pkg::ST_CABLE_DISC;
          end else if (link_up_i) begin
            state_next = traffic_i ? pps_pkg::ST_ACTIVE : pps_pkg::ST_IDLE;
          end
        end
        pps_pkg::ST_ACTIVE, pps_pkg::ST_IDLE: begin
          if (!energy_i) begin
            state_next = pps_pkg::ST_CABLE_DISC;
          end else if (!link_up_i) begin
            state_next = pps_pkg::ST_NO_LINK;
          end else begin
            state_next = traffic_i ? pps_pkg::ST_ACTIVE : pps_pkg::ST_IDLE;
          end
        end
        pps_pkg::ST_CABLE_DISC: if (energy_i) begin
          state_next = pps_pkg::ST_BREAK_WAIT;
        end
        pps_pkg::ST_BREAK_WAIT: if (break_done) begin
          state_next = pps_pkg::ST_NO_LINK;
        end
        pps_pkg::ST_IEEE_PD: state_next = pps_pkg::ST_NO_LINK;
        default: state_next = pps_pkg::ST_PWR_UP;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pps_pkg::ST_PWR_UP;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Power controls
  // ************************************************************
  // Decoded from the next state so controls line up with the state
  always_comb begin
    phy_pd_next = 1'b0;
    clk_gate_next = 1'b0;
    pcie_ei_next = 1'b0;
    pcie_pd_next = 1'b0;
    energy_mode_next = 1'b0;
    iface_rst_next = 1'b0;
    an_en_next = 1'b0;
    rx_lpi_next = 1'b0;
    tx_lpi_next = 1'b0;
    cable_gone_next = cable_gone_reg;
    // The hold counter still reads zero in its loading cycle, so the load itself keeps the indicator lit
    led_next = linked_next || (led_reg && (led_load || !led_done) && !pin_pd);
    case (state_next)
      pps_pkg::ST_PIN_PD: begin
        phy_pd_next = 1'b1;
        clk_gate_next = 1'b1;
        iface_rst_next = 1'b1;
        // Electrical idle only once the PHY is already down
        pcie_ei_next = pcie_en_i && phy_pd_reg;
      end
      pps_pkg::ST_IEEE_PD: begin
        // Stay-active mode keeps everything running
        phy_pd_next = pd_mode_reg;
        clk_gate_next = pd_mode_reg;
        pcie_ei_next = pd_mode_reg;
      end
      pps_pkg::ST_IF_INIT, pps_pkg::ST_PWR_UP: iface_rst_next = (state_next == pps_pkg::ST_PWR_UP);
      pps_pkg::ST_CABLE_DISC: begin
        energy_mode_next = 1'b1;
        pcie_pd_next = 1'b1;
        cable_gone_next = 1'b1;
      end
      pps_pkg::ST_BREAK_WAIT: cable_gone_next = 1'b0;
      pps_pkg::ST_NO_LINK: an_en_next = 1'b1;
      pps_pkg::ST_ACTIVE, pps_pkg::ST_IDLE: begin
        an_en_next = 1'b1;
        // Idle lets the host interface rest; active never does
        pcie_ei_next = (state_next == pps_pkg::ST_IDLE) && !mac_tx_lpi_req_i;
        rx_lpi_next = lpi_en_reg && partner_lpi_i;
        tx_lpi_next = mac_tx_lpi_req_i;
      end
      default: an_en_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phy_pd_reg <= 1'b0;
      clk_gate_reg <= 1'b0;
      pcie_ei_reg <= 1'b0;
      pcie_pd_reg <= 1'b0;
      energy_mode_reg <= 1'b0;
      iface_rst_reg <= 1'b1;
      an_en_reg <= 1'b0;
      rx_lpi_reg <= 1'b0;
      tx_lpi_reg <= 1'b0;
      cable_gone_reg <= 1'b0;
      led_reg <= 1'b0;
    end else begin
      phy_pd_reg <= phy_pd_next;
      clk_gate_reg <= clk_gate_next;
      pcie_ei_reg <= pcie_ei_next;
      pcie_pd_reg <= pcie_pd_next;
      energy_mode_reg <= energy_mode_next;
      iface_rst_reg <= iface_rst_next;
      an_en_reg <= an_en_next;
      rx_lpi_reg <= rx_lpi_next;
      tx_lpi_reg <= tx_lpi_next;
      cable_gone_reg <= cable_gone_next;
      led_reg <= led_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o = rdata_reg;
  assign state_o = state_reg;
  assign iface_rst_o = iface_rst_reg;
  assign an_enable_o = an_en_reg;
  assign phy_pd_o = phy_pd_reg;
  assign clk_gate_o = clk_gate_reg;
  assign pcie_ei_o = pcie_ei_reg;
  assign pcie_pd_o = pcie_pd_reg;
  assign energy_mode_o = energy_mode_reg;
  assign cable_gone_o = cable_gone_reg;
  assign rx_lpi_ind_o = rx_lpi_reg;
  assign rx_off_o = rx_lpi_reg;
  assign tx_lpi_o = tx_lpi_reg;
  assign tx_off_o = tx_lpi_reg;
  assign link_led_o = led_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_SUPPLY_PD: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !lan_supply_good_n_i |=> state_reg == pps_pkg::ST_PIN_PD && phy_pd_o)
    else $error("supply-good low did not force power down");
  AST_PIN_PD: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !lan_off_n_i |=> state_reg == pps_pkg::ST_PIN_PD && phy_pd_o && clk_gate_o && iface_rst_o)
    else $error("LAN-off low did not force power down");
  AST_EI_AFTER_PHY: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == pps_pkg::ST_PIN_PD && $rose(pcie_ei_o)) |-> $past(phy_pd_o))
    else $error("PCIe idle came before PHY power down");
  AST_SW_PD: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (reg_wr_i && reg_addr_i == pps_pkg::CTRL_ADDR && reg_wdata_i[pps_pkg::CTRL_PWR_DOWN_BIT]
      && !pin_pd) ##1 !pin_pd |=> state_reg == pps_pkg::ST_IEEE_PD)
    else $error("power-down bit did not enter IEEE power down");
  AST_PD_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == pps_pkg::ST_IEEE_PD && state_next == pps_pkg::ST_IEEE_PD)
      |=> phy_pd_o == $past(pd_mode_reg) && clk_gate_o == $past(pd_mode_reg))
    else $error("power-down mode not followed");
  AST_DISC_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    state_reg == pps_pkg::ST_CABLE_DISC |-> energy_mode_o && pcie_pd_o && cable_gone_o)
    else $error("cable-disconnect controls wrong");
  AST_ENERGY_EXIT: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state_reg == pps_pkg::ST_CABLE_DISC && energy_i && !pin_pd && !pwr_down_reg && !mac_pd_req_i)
      |=> !cable_gone_o && state_reg == pps_pkg::ST_BREAK_WAIT)
    else $error("energy did not clear cable-gone");
  AST_BREAK_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    state_reg == pps_pkg::ST_BREAK_WAIT |-> !an_enable_o ##0
      (state_next != pps_pkg::ST_NO_LINK || break_done))
    else $error("advertising before break-link wait ended");
  AST_RX_LPI: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(rx_lpi_ind_o) |-> $past(partner_lpi_i) && $past(lpi_en_reg) && rx_off_o)
    else $error("receive LPI without partner LPI");
  AST_LED_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (linked_now && !linked_next && !pin_pd) |=> link_led_o && !led_done)
    else $error("link indicator dropped as the link went away");
endmodule

// *** tb/pps_mac_model.sv ***
// MAC partner model: brings the interconnect up and configures the PHY.
// Assumes it shares the core clock and watches the manager's interface reset.
`timescale 1ns/100ps
module pps_mac_model #(
  parameter int DLY = 3
) (
  input wire logic core_clk_i,   // Core clock
  input wire logic rst_n_i,      // Reset, active low
  input wire logic iface_rst_i,  // Interconnect reset from the manager
  output logic link_init_done_o, // Interconnect initialised
  output logic mdio_cfg_done_o   // MDIO configuration finished
);
  int cnt;
  // ************************************************************
  // Bring-up sequence; DLY sets a prompt or a slow MAC
  // ************************************************************
  // Configuration comes DLY cycles after init on the same count, whether or not the design waited for init
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i || iface_rst_i) begin
      cnt <= 0;
      link_init_done_o <= 1'b0;
      mdio_cfg_done_o <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == DLY) link_init_done_o <= 1'b1;
      if (cnt == 2 * DLY) mdio_cfg_done_o <= 1'b1;
    end
  end
endmodule

// *** tb/pps_power_mgr_tb.sv ***
// Self-checking bench of the power-state manager with a MAC model.
// Assumes the package state codes and short simulation wait counts.
`timescale 1ns/100ps
module pps_power_mgr_tb;
  localparam int BRK = 20;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic sg_n = 1'b1, off_n = 1'b1, pen = 1'b1, pd_req = 1'b0, tx_req = 1'b0;
  logic p_lpi = 1'b0, energy = 1'b1, link_up = 1'b0, traffic = 1'b0;
  logic init_d, cfg_d, ifr, an_en, phy_pd, cg, ei, ppd, emode, cgone, rxi, rxo, txl, txo, led;
  logic [3:0] state;
  int bad_count = 0, comparisons = 0;
  // ************************************************************
  // Clock, design and partner
  // ************************************************************
  always #2.5 clk = ~clk;
  pps_power_mgr #(.BREAK_CYC(BRK), .LED_CYC(30)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .lan_supply_good_n_i(sg_n),
    .lan_off_n_i(off_n), .pcie_en_i(pen), .link_init_done_i(init_d), .mdio_cfg_done_i(cfg_d),
    .mac_pd_req_i(pd_req), .mac_tx_lpi_req_i(tx_req), .partner_lpi_i(p_lpi), .energy_i(energy),
    .link_up_i(link_up), .traffic_i(traffic), .state_o(state), .iface_rst_o(ifr),
    .an_enable_o(an_en), .phy_pd_o(phy_pd), .clk_gate_o(cg), .pcie_ei_o(ei), .pcie_pd_o(ppd),
    .energy_mode_o(emode), .cable_gone_o(cgone), .rx_lpi_ind_o(rxi), .rx_off_o(rxo),
    .tx_lpi_o(txl), .tx_off_o(txo), .link_led_o(led));
  pps_mac_model #(.DLY(3)) mac (.core_clk_i(clk), .rst_n_i(rst_n), .iface_rst_i(ifr),
    .link_init_done_o(init_d), .mdio_cfg_done_o(cfg_d));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Bounded wait, so a stuck state machine cannot hang the run
  task automatic wait_st(input logic [3:0] s);
    int n = 0;
    while (state !== s && n < 200) begin
      tick(1);
      n++;
    end
    chk({28'h0, state}, {28'h0, s});
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_boot();
    wait_st(pps_pkg::ST_NO_LINK);
    chk({31'h0, an_en}, 32'h1);
    rreg(pps_pkg::CTRL_ADDR, 32'h1);
    rreg(8'h08, 32'h0);
    $display("boot test done");
  endtask
  task automatic t_lpi();
    link_up <= 1'b1;
    traffic <= 1'b1;
    p_lpi <= 1'b1;
    wait_st(pps_pkg::ST_ACTIVE);
    chk({cg, ei, rxi}, 3'b000);
    wreg(pps_pkg::CTRL_ADDR, 32'h3);
    tick(2);
    chk({rxi, rxo}, 2'b11);
    tx_req <= 1'b1;
    tick(2);
    chk({txl, txo}, 2'b11);
    rreg(pps_pkg::STAT_ADDR, 32'h166);
    tx_req <= 1'b0;
    traffic <= 1'b0;
    p_lpi <= 1'b0;
    wait_st(pps_pkg::ST_IDLE);
    tick(1);
    chk({ei, txl}, 2'b10);
    $display("lpi test done");
  endtask
  task automatic t_cable();
    int n = 0;
    energy <= 1'b0;
    wait_st(pps_pkg::ST_CABLE_DISC);
    chk({emode, ppd, cgone, led}, 4'hF);
    energy <= 1'b1;
    wait_st(pps_pkg::ST_BREAK_WAIT);
    chk({cgone, an_en}, 2'b00);
    while (state === pps_pkg::ST_BREAK_WAIT && n < 100) begin
      tick(1);
      n++;
    end
    chk(n, BRK + 1);
    chk({state, an_en}, {pps_pkg::ST_NO_LINK, 1'b1});
    $display("cable test done");
  endtask
  task automatic t_ieee();
    link_up <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      wreg(pps_pkg::CTRL_ADDR, 32'h800 | m);
      wait_st(pps_pkg::ST_IEEE_PD);
      tick(1);
      chk({phy_pd, cg, ei}, m ? 3'b111 : 3'b000);
      wreg(pps_pkg::CTRL_ADDR, m);
      wait_st(pps_pkg::ST_NO_LINK);
    end
    pd_req <= 1'b1;
    wait_st(pps_pkg::ST_IEEE_PD);
    pd_req <= 1'b0;
    wait_st(pps_pkg::ST_NO_LINK);
    $display("ieee test done");
  endtask
  // Pin power down races an in-band request; the pin must win
  task automatic t_pin();
    for (int k = 0; k < 2; k++) begin
      pd_req <= 1'b1;
      pen <= (k == 0);
      if (k == 1) sg_n <= 1'b0;
      else off_n <= 1'b0;
      wait_st(pps_pkg::ST_PIN_PD);
      chk({phy_pd, cg, ifr, ei}, 4'b1110);
      tick(1);
      chk({31'h0, ei}, (k == 0) ? 32'h1 : 32'h0);
      pd_req <= 1'b0;
      pen <= 1'b1;
      sg_n <= 1'b1;
      off_n <= 1'b1;
      wait_st(pps_pkg::ST_IF_INIT);
      wait_st(pps_pkg::ST_NO_LINK);
      chk({ifr, an_en}, 2'b01);
    end
    $display("pin test done");
  endtask
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ************************************************************
  // Sequence and watchdog
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    t_boot();
    t_lpi();
    t_cable();
    t_ieee();
    t_pin();
    tally_and_finish();
  end
  // Whole run takes about 100 cycles; over a hundred times that means a hang
  initial begin
    #75000;
    bad_count++;
    tally_and_finish();
  end
endmodule
